/* logic/rcb_core.sv */
`timescale 1ns/1ns
// Functional notes
// - Timebase counts 32768 Hz oscillator edges
// - Correction alters second length at 256 stage
// - Magnitude is control bits four to zero
// - Sign bit one adds, zero removes
// - 64 minute cycle, shorten 128 or lengthen 256
// - Only first 2N minutes are corrected
// - Test wave needs run, test on, alarm off
// - Also needs steering set or watchdog zero
// - Test wave ignores calibration entirely
// - Test pin is open drain, low only
// - Frequency test bit clears at power up
// - Input A: ignore under 50 ns
// - Input B: ignore under 20 ms
// - Reset output held 40 ms after release
// - Battery check at power up, daily after
// - Failed check sets battery low flag
// - Flag holds until a passing check
// - No battery checks without main supply
// - Power up clears listed control bits
// - Reset inputs ignored while output stretches
// - Watchdog on pin suppresses test wave
module rcb_core #(
  parameter int FILT_B_CYCLES  = rcb_pkg::FILT_B_CYC,
  parameter int STRETCH_CYCLES = rcb_pkg::STRETCH_CYC,
  parameter int CHECK_SECONDS  = rcb_pkg::CHECK_SECS
) (
  input  wire logic                  clk,
  input  wire logic                  rst_n,
  input  wire logic                  clk_en,
  input  wire logic                  osc_in,
  input  wire rcb_pkg::rcb_bus_in_s  bus_in,
  output rcb_pkg::rcb_bus_out_s      bus_out,
  input  wire logic                  reset_request_a_n,
  input  wire logic                  reset_request_b_n,
  input  wire logic                  battery_ok,
  input  wire logic                  main_supply_ok,
  input  wire logic                  irq_test_pin_i,
  output rcb_pkg::rcb_od_s           irq_test_pin,
  input  wire logic                  reset_out_i,
  output rcb_pkg::rcb_od_s           reset_out
);
  import rcb_pkg::*;

  localparam logic [RST_CW-1:0] FA_LAST = RST_CW'(FILT_A_CYC - 1);
  localparam logic [RST_CW-1:0] FB_LAST = RST_CW'(FILT_B_CYCLES - 1);
  localparam logic [RST_CW-1:0] ST_LAST = RST_CW'(STRETCH_CYCLES - 1);
  localparam logic [16:0]       CK_LAST = 17'(CHECK_SECONDS - 1);
  localparam logic [4:0]        TP_LAST = 5'(TEST_HALF - 1);

  // ==========================================================================
  // Pin synchronisation
  logic [SYNC_W-1:0] sync_q;
  logic              ce_n_s;
  logic              we_n_s;
  logic              oe_n_s;
  logic [3:0]        addr_s;
  logic [7:0]        wdata_s;
  logic              osc_s;
  logic              req_a_s;
  logic              req_b_s;
  logic              batt_ok_s;
  logic              vcc_ok_s;

  rcb_sync #(
    .W       (SYNC_W),
    .RST_VAL (SYNC_RST)
  ) u_sync (
    .clk    (clk),
    .rst_n  (rst_n),
    .clk_en (clk_en),
    .d      ({bus_in, osc_in, reset_request_a_n, reset_request_b_n,
              battery_ok, main_supply_ok}),
    .q      (sync_q)
  );

  assign {ce_n_s, we_n_s, oe_n_s, addr_s, wdata_s, osc_s, req_a_s,
          req_b_s, batt_ok_s, vcc_ok_s} = sync_q;

  // ==========================================================================
  // Helpers
  rcb_state_s s_r;
  rcb_state_s s_nxt;

  function automatic logic [15:0] next_len(input logic [5:0] min,
                                           input logic [5:0] sec,
                                           input logic [4:0] mag,
                                           input logic       pos);
    // One second per eligible minute; 128 is half a divide-by-256 period,
    // 256 is a whole one, so the edit lands on that stage's boundary.
    if (sec == 6'h00 && min < {mag, 1'b0} && min < CAL_EDGE_MIN)
      return pos ? SEC_SHORT : SEC_LONG;
    return SEC_NOMINAL;
  endfunction : next_len

  function automatic logic [7:0] rd_mux(input rcb_state_s st,
                                        input logic [3:0] a);
    case (a)
      ADDR_FLAGS:       return 8'(st.batt_low) << BIT_BATT_LOW;
      ADDR_ALARM_MONTH: return st.reg_alarm;
      ADDR_WATCHDOG:    return st.reg_wdog;
      ADDR_CONTROL:     return st.reg_ctrl;
      ADDR_SECONDS:     return st.reg_sec;
      ADDR_WEEKDAY:     return st.reg_wday;
      default:          return 8'h00;
    endcase
  endfunction : rd_mux

  logic osc_tick;
  logic sec_end;
  logic test_en;
  logic wr_live;
  logic wr_end;
  logic check_now;
  logic hit_a;
  logic hit_b;

  // A stopped oscillator freezes the divider, the test wave and the
  // daily check timer alike, as a real halted crystal would.
  assign osc_tick  = osc_s && !s_r.osc_prev && !s_r.reg_sec[BIT_HALT];
  assign sec_end   = osc_tick && s_r.div == s_r.sec_len - 16'h0001;
  assign test_en   = !s_r.reg_sec[BIT_HALT] && s_r.reg_wday[BIT_FREQ]
                     && !s_r.reg_alarm[BIT_AFE]
                     && (s_r.reg_wdog[BIT_WDS] || s_r.reg_wdog == 8'h00);
  assign wr_live   = !ce_n_s && !we_n_s;
  assign wr_end    = s_r.wr_act && !wr_live;
  assign check_now = (!s_r.boot_done || s_r.intv_pend) && vcc_ok_s;
  assign hit_a     = !req_a_s && s_r.filt_a == FA_LAST;
  assign hit_b     = !req_b_s && s_r.filt_b == FB_LAST;

  // ==========================================================================
  // Next-state logic
  always_comb
  begin
    s_nxt          = s_r;
    s_nxt.osc_prev = osc_s;

    // Divider chain and calibration cycle.
    if (osc_tick)
      s_nxt.div = s_r.div + 16'h0001;
    if (sec_end)
    begin
      s_nxt.div = 16'h0000;
      if (s_r.sec_idx == SEC_LAST)
      begin
        s_nxt.sec_idx = 6'h00;
        s_nxt.min_idx = s_r.min_idx + 6'h01;
      end
      else
        s_nxt.sec_idx = s_r.sec_idx + 6'h01;
      // Calibration is sampled only here, so a write never cuts a
      // second that is already being counted.
      s_nxt.cal_mag_act = s_r.reg_ctrl[CAL_MSB:0];
      s_nxt.cal_pos_act = s_r.reg_ctrl[BIT_SIGN];
      s_nxt.sec_len     = next_len(s_nxt.min_idx, s_nxt.sec_idx,
                                   s_nxt.cal_mag_act,
                                   s_nxt.cal_pos_act);
    end

    // Test wave from the raw oscillator, untouched by calibration.
    if (osc_tick)
    begin
      if (s_r.tp_cnt == TP_LAST)
      begin
        s_nxt.tp_cnt   = 5'h00;
        s_nxt.tp_phase = !s_r.tp_phase;
      end
      else
        s_nxt.tp_cnt = s_r.tp_cnt + 5'h01;
    end
    s_nxt.irq_oe = test_en && !s_r.tp_phase;

    // Reset input filtering and output stretch.
    unique case (s_r.rs)
      RS_IDLE:
      begin
        s_nxt.filt_a = req_a_s ? '0 : (hit_a ? s_r.filt_a
                                             : s_r.filt_a + 1'b1);
        s_nxt.filt_b = req_b_s ? '0 : (hit_b ? s_r.filt_b
                                             : s_r.filt_b + 1'b1);
        if (hit_a || hit_b)
        begin
          s_nxt.rs     = RS_WAIT;
          s_nxt.rst_oe = 1'b1;
        end
      end
      RS_WAIT:
      begin
        s_nxt.filt_a = '0;
        s_nxt.filt_b = '0;
        if (req_a_s && req_b_s)
        begin
          s_nxt.rs      = RS_STRETCH;
          s_nxt.stretch = '0;
        end
      end
      RS_STRETCH:
      begin
        // Inputs are not watched here at all.
        s_nxt.filt_a = '0;
        s_nxt.filt_b = '0;
        if (s_r.stretch == ST_LAST)
        begin
          s_nxt.rs     = RS_IDLE;
          s_nxt.rst_oe = 1'b0;
        end
        else
          s_nxt.stretch = s_r.stretch + 1'b1;
      end
      default:
      begin
        s_nxt.rs     = RS_STRETCH;
        s_nxt.rst_oe = 1'b1;
      end
    endcase

    // Battery monitoring.
    if (check_now)
    begin
      s_nxt.batt_low  = !batt_ok_s;
      s_nxt.boot_done = 1'b1;
      s_nxt.intv_pend = 1'b0;
    end
    if (sec_end)
    begin
      if (s_r.intv_cnt == CK_LAST)
      begin
        s_nxt.intv_cnt  = '0;
        s_nxt.intv_pend = 1'b1;
      end
      else
        s_nxt.intv_cnt = s_r.intv_cnt + 17'h00001;
    end

    // Bytewide bus: a write lands when the strobe pair ends.
    s_nxt.wr_act = wr_live;
    if (wr_live)
    begin
      s_nxt.wr_addr = addr_s;
      s_nxt.wr_data = wdata_s;
    end
    if (wr_end)
    begin
      case (s_r.wr_addr)
        ADDR_ALARM_MONTH: s_nxt.reg_alarm = s_r.wr_data & MASK_ALARM;
        ADDR_WATCHDOG:    s_nxt.reg_wdog  = s_r.wr_data;
        ADDR_CONTROL:     s_nxt.reg_ctrl  = s_r.wr_data;
        ADDR_SECONDS:     s_nxt.reg_sec   = s_r.wr_data;
        ADDR_WEEKDAY:     s_nxt.reg_wday  = s_r.wr_data & MASK_WEEKDAY;
        default:          s_nxt.reg_sec   = s_r.reg_sec;
      endcase
    end
    s_nxt.rdata    = rd_mux(s_r, addr_s);
    s_nxt.rdata_oe = !ce_n_s && !oe_n_s && we_n_s;
  end

  // ==========================================================================
  // State register
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      s_r <= STATE_RST;
    else if (clk_en)
      s_r <= s_nxt;
  end

  assign bus_out.rdata    = s_r.rdata;
  assign bus_out.rdata_oe = s_r.rdata_oe;
  assign irq_test_pin.o   = 1'b0;
  assign irq_test_pin.oe  = s_r.irq_oe;
  assign reset_out.o      = 1'b0;
  assign reset_out.oe     = s_r.rst_oe;

  // ==========================================================================
  // Assertions
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  sequence sec_end_seq;
    clk_en && sec_end;
  endsequence

  sequence stretch_run_seq;
    clk_en && s_r.rs == RS_STRETCH && s_r.stretch != ST_LAST;
  endsequence

  a_second_plain: assert property (sec_end_seq ##0 s_nxt.sec_idx != 6'h00
    |=> s_r.sec_len == SEC_NOMINAL)
    else $error("corrected second outside second zero");
  a_cal_span: assert property (sec_end_seq |=>
    s_r.min_idx < {s_r.cal_mag_act, 1'b0} || s_r.sec_len == SEC_NOMINAL)
    else $error("minute beyond 2N was corrected");
  a_cal_applied: assert property (sec_end_seq ##0 (s_nxt.sec_idx == 6'h00
    && s_nxt.min_idx < {s_r.reg_ctrl[CAL_MSB:0], 1'b0}) |=>
    s_r.sec_len != SEC_NOMINAL)
    else $error("eligible minute left uncorrected");
  a_cal_sign: assert property (sec_end_seq |=>
    (s_r.sec_len != SEC_SHORT || s_r.cal_pos_act) &&
    (s_r.sec_len != SEC_LONG || !s_r.cal_pos_act))
    else $error("correction direction wrong");
  a_len_held: assert property (clk_en && !sec_end |=>
    $stable(s_r.sec_len))
    else $error("second length changed mid second");
  a_test_gate: assert property (clk_en && !test_en |=>
    !irq_test_pin.oe)
    else $error("test wave driven while disabled");
  a_test_rate: assert property ($changed(s_r.tp_phase) |->
    $past(s_r.tp_cnt) == TP_LAST)
    else $error("test wave half period wrong");
  a_filter_a: assert property (clk_en && s_r.rs == RS_IDLE &&
    s_r.filt_a != FA_LAST && s_r.filt_b != FB_LAST |=>
    s_r.rs == RS_IDLE && !reset_out.oe)
    else $error("short reset pulse accepted");
  a_stretch_hold: assert property (stretch_run_seq |=>
    reset_out.oe && s_r.rs == RS_STRETCH)
    else $error("reset output released early");
  a_batt_check: assert property (clk_en && check_now |=>
    s_r.batt_low != $past(batt_ok_s))
    else $error("battery flag not updated by check");
  a_batt_keep: assert property (clk_en && !check_now |=>
    $stable(s_r.batt_low))
    else $error("battery flag changed without check");
  a_power_clear: assert property ($rose(rst_n) |->
    s_r.reg_wday[BIT_FREQ] == 1'b0 && s_r.reg_wdog == 8'h00 &&
    !s_r.reg_alarm[BIT_AFE] && !s_r.reg_alarm[BIT_ABE] &&
    !s_r.reg_ctrl[BIT_WRITE])
    else $error("control bits not cleared at power up");

endmodule : rcb_core

/* inc/rcb_pkg.sv */
package rcb_pkg;

  // ==========================================================================
  // Register map and field layout
  localparam logic [3:0] ADDR_FLAGS       = 4'h0;
  localparam logic [3:0] ADDR_ALARM_MONTH = 4'h6;
  localparam logic [3:0] ADDR_WATCHDOG    = 4'h7;
  localparam logic [3:0] ADDR_CONTROL     = 4'h8;
  localparam logic [3:0] ADDR_SECONDS     = 4'h9;
  localparam logic [3:0] ADDR_WEEKDAY     = 4'hc;

  localparam int BIT_BATT_LOW = 4;
  localparam int BIT_AFE      = 7;
  localparam int BIT_ABE      = 5;
  localparam int BIT_WDS      = 7;
  localparam int BIT_HALT     = 7;
  localparam int BIT_FREQ     = 6;
  localparam int BIT_SIGN     = 5;
  localparam int BIT_WRITE    = 7;
  localparam int CAL_MSB      = 4;

  // Bits that must stay zero are masked on write.
  localparam logic [7:0] MASK_ALARM   = 8'hbf;
  localparam logic [7:0] MASK_WEEKDAY = 8'h47;
  localparam logic [7:0] REG_RST      = 8'h00;

  // ==========================================================================
  // Oscillator and calibration
  localparam int          OSC_HZ       = 32768;
  localparam int          CAL_SHORTEN  = 128;
  localparam int          CAL_LENGTHEN = 256;
  localparam logic [15:0] SEC_NOMINAL  = 16'(OSC_HZ);
  localparam logic [15:0] SEC_SHORT    = 16'(OSC_HZ - CAL_SHORTEN);
  localparam logic [15:0] SEC_LONG     = 16'(OSC_HZ + CAL_LENGTHEN);
  localparam logic [5:0]  SEC_LAST     = 6'h3b;
  localparam logic [5:0]  CAL_EDGE_MIN = 6'h3e;
  localparam int          TEST_HZ      = 512;
  localparam int          TEST_HALF    = OSC_HZ / (2 * TEST_HZ);

  // ==========================================================================
  // Timing on the 125 MHz system clock
  localparam int CLK_PERIOD_NS = 8;
  localparam int FILT_A_NS     = 50;
  localparam int FILT_A_CYC    = (FILT_A_NS + CLK_PERIOD_NS - 1)
                                 / CLK_PERIOD_NS;
  localparam int FILT_B_MS     = 20;
  localparam int FILT_B_CYC    = (FILT_B_MS * 1000000 + CLK_PERIOD_NS - 1)
                                 / CLK_PERIOD_NS;
  localparam int STRETCH_MS    = 40;
  localparam int STRETCH_CYC   = (STRETCH_MS * 1000000 + CLK_PERIOD_NS - 1)
                                 / CLK_PERIOD_NS;
  localparam int CHECK_HOURS   = 24;
  localparam int CHECK_SECS    = CHECK_HOURS * 3600;
  localparam int RST_CW        = 23;

  // ==========================================================================
  // Carriers and state
  typedef struct packed {
    logic       ce_n;
    logic       we_n;
    logic       oe_n;
    logic [3:0] addr;
    logic [7:0] wdata;
  } rcb_bus_in_s;

  typedef struct packed {
    logic [7:0] rdata;
    logic       rdata_oe;
  } rcb_bus_out_s;

  typedef struct packed {
    logic o;
    logic oe;
  } rcb_od_s;

  localparam int          SYNC_W   = 20;
  localparam logic [19:0] SYNC_RST = 20'hffffe;

  typedef enum logic [1:0] {
    RS_STRETCH = 2'b00,
    RS_IDLE    = 2'b01,
    RS_WAIT    = 2'b11
  } rcb_rs_e;

  typedef struct packed {
    rcb_rs_e           rs;
    logic [RST_CW-1:0] filt_a;
    logic [RST_CW-1:0] filt_b;
    logic [RST_CW-1:0] stretch;
    logic              rst_oe;
    logic              osc_prev;
    logic [15:0]       div;
    logic [15:0]       sec_len;
    logic [5:0]        sec_idx;
    logic [5:0]        min_idx;
    logic [4:0]        cal_mag_act;
    logic              cal_pos_act;
    logic [4:0]        tp_cnt;
    logic              tp_phase;
    logic              irq_oe;
    logic [7:0]        reg_alarm;
    logic [7:0]        reg_wdog;
    logic [7:0]        reg_ctrl;
    logic [7:0]        reg_sec;
    logic [7:0]        reg_wday;
    logic              batt_low;
    logic              boot_done;
    logic              intv_pend;
    logic [16:0]       intv_cnt;
    logic              wr_act;
    logic [3:0]        wr_addr;
    logic [7:0]        wr_data;
    logic [7:0]        rdata;
    logic              rdata_oe;
  } rcb_state_s;

  // The oscillator synchroniser leaves reset high, so the edge detector
  // starts high too; otherwise the first edge after reset is a false tick.
  localparam rcb_state_s STATE_RST = '{
    rs:       RS_STRETCH,
    rst_oe:   1'b1,
    osc_prev: 1'b1,
    sec_len:  SEC_NOMINAL,
    default:  '0
  };

endpackage : rcb_pkg

/* logic/rcb_sync.sv */
`timescale 1ns/1ns
module rcb_sync #(
  parameter int             W       = 1,
  parameter logic [W-1:0]   RST_VAL = '0
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic         clk_en,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  // ==========================================================================
  // Two-stage synchroniser; the first stage feeds only the second.
  logic [W-1:0] meta_r;

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      meta_r <= RST_VAL;
      q      <= RST_VAL;
    end
    else if (clk_en)
    begin
      meta_r <= d;
      q      <= meta_r;
    end
  end

endmodule : rcb_sync

/* tb/rcb_cpu_model.sv */
`timescale 1ns/1ns
module rcb_cpu_model (
  input  wire logic                  clk,
  output rcb_pkg::rcb_bus_in_s       bus,
  input  wire rcb_pkg::rcb_bus_out_s bus_out,
  output logic                       rd_valid,
  output logic [8:0]                 rd_data
);
  import rcb_pkg::*;

  // ==========================================================================
  // Idle bus
  initial
  begin
    bus      = '{ce_n: 1'b1, we_n: 1'b1, oe_n: 1'b1, addr: 4'h0, wdata: 8'h00};
    rd_valid = 1'b0;
    rd_data  = 9'h000;
  end

  // ==========================================================================
  // One bytewide cycle
  // The pins are asynchronous to the block, so strobes are held five cycles
  // and the gap is at least eight, well above the two-cycle synchroniser minimum.
  task automatic access(input logic       wr,
                        input logic [3:0] a,
                        input logic [7:0] d);
    @(posedge clk);
    bus <= '{ce_n: 1'b0, we_n: ~wr, oe_n: wr, addr: a, wdata: d};
    repeat (5) @(posedge clk);
    if (!wr)
    begin
      rd_data  <= {bus_out.rdata_oe, bus_out.rdata};
      rd_valid <= 1'b1;
    end
    bus.ce_n <= 1'b1;
    bus.we_n <= 1'b1;
    bus.oe_n <= 1'b1;
    @(posedge clk);
    rd_valid <= 1'b0;
    // Released lines must not keep looking like the last transfer.
    bus.addr  <= ~a;
    bus.wdata <= ~d;
    repeat (6) @(posedge clk);
  endtask : access

endmodule : rcb_cpu_model

/* tb/rcb_core_bench.sv */
`timescale 1ns/1ns
module rcb_core_bench;
  import rcb_pkg::*;

  // ==========================================================================
  // Scaled counts: filter B and stretch are cut down, with stretch three times filter B.
  localparam int FB    = 20;
  localparam int STR   = 60;
  localparam int HALF  = 128;
  localparam int LIMIT = 60000;

  logic         clk     = 1'b0;
  logic         rst_n   = 1'b0;
  logic         osc     = 1'b0;
  logic         osc_ph  = 1'b0;
  logic         req_a_n = 1'b1;
  logic         req_b_n = 1'b1;
  logic         bat_ok  = 1'b0;
  logic         main_ok = 1'b1;
  logic         irq_lvl;
  logic         rst_lvl;
  rcb_bus_in_s  bus_in;
  rcb_bus_out_s bus_out;
  rcb_od_s      irq_pin;
  rcb_od_s      rst_pin;
  logic         rd_valid;
  logic [8:0]   rd_data;
  logic [8:0]   exp_q[$];
  int           mismatches = 0;
  int           checks     = 0;
  int           cycles     = 0;
  int           seed       = 66265;

  always #4 clk = ~clk;

  // The crystal runs four clocks per period so that the test wave, 32
  // crystal edges per half, is a short and exact 128 clocks.
  always @(posedge clk)
  begin
    osc_ph <= ~osc_ph;
    if (osc_ph)
      osc <= ~osc;
  end

  // Both open-drain pins have pull-ups.
  assign irq_lvl = irq_pin.oe ? irq_pin.o : 1'b1;
  assign rst_lvl = rst_pin.oe ? rst_pin.o : 1'b1;

  rcb_core #(
    .FILT_B_CYCLES  (FB),
    .STRETCH_CYCLES (STR),
    .CHECK_SECONDS  (3)
  ) uut (
    .clk               (clk),
    .rst_n             (rst_n),
    .clk_en            (1'b1),
    .osc_in            (osc),
    .bus_in            (bus_in),
    .bus_out           (bus_out),
    .reset_request_a_n (req_a_n),
    .reset_request_b_n (req_b_n),
    .battery_ok        (bat_ok),
    .main_supply_ok    (main_ok),
    .irq_test_pin_i    (irq_lvl),
    .irq_test_pin      (irq_pin),
    .reset_out_i       (rst_lvl),
    .reset_out         (rst_pin)
  );

  rcb_cpu_model cpu (
    .clk      (clk),
    .bus      (bus_in),
    .bus_out  (bus_out),
    .rd_valid (rd_valid),
    .rd_data  (rd_data)
  );

  // ==========================================================================
  // Checking
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic end_sim();
    $display("Checks %0d, mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : end_sim

  // Read results are matched against the oldest expectation.
  always @(posedge clk)
  begin
    if (rd_valid === 1'b1)
      check(16'(rd_data), exp_q.size() > 0 ? 16'(exp_q.pop_front()) : 16'hffff);
  end

  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == LIMIT)
    begin
      mismatches++;
      end_sim();
    end
  end

  // ==========================================================================
  // Stimulus tasks
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    cpu.access(1'b1, a, d);
  endtask : wr

  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    exp_q.push_back({1'b1, e});
    cpu.access(1'b0, a, 8'h00);
  endtask : rd

  task automatic power_up(input logic bat, input logic main);
    @(posedge clk);
    rst_n   <= 1'b0;
    bat_ok  <= bat;
    main_ok <= main;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    for (int n = 0; n < 400 && rst_pin.oe !== 1'b0; n++)
      @(posedge clk);
    check(16'(rst_pin.oe), 16'h0000);
  endtask : power_up

  task automatic wave(input logic on);
    int   last  = -1;
    int   edges = 0;
    logic prev;
    repeat (100) @(posedge clk);
    prev = irq_lvl;
    for (int n = 0; n < 1200; n++)
    begin
      @(posedge clk);
      if (irq_lvl !== prev)
      begin
        if (last >= 0)
          check(16'(n - last), 16'(HALF));
        last = n;
        edges++;
      end
      prev = irq_lvl;
    end
    check(16'(edges >= 8), 16'(on));
    check(16'(irq_pin.o), 16'h0000);
  endtask : wave

  // A second request is thrown in during the stretch when nest is set.
  task automatic rst_pulse(input logic use_b, input int len,
                           input logic hit, input logic nest);
    int n = 0;
    @(posedge clk);
    if (use_b)
      req_b_n <= 1'b0;
    else
      req_a_n <= 1'b0;
    repeat (len) @(posedge clk);
    req_a_n <= 1'b1;
    req_b_n <= 1'b1;
    if (hit)
    begin
      do
      begin
        @(posedge clk);
        n++;
        if (nest && n == 5)
          req_a_n <= 1'b0;
        if (n == 30)
          req_a_n <= 1'b1;
      end while (rst_pin.oe === 1'b1 && n < 300);
      check(16'(n >= STR && n <= STR + 8), 16'h0001);
    end
    else
    begin
      repeat (40)
      begin
        @(posedge clk);
        if (rst_pin.oe !== 1'b0)
          n++;
      end
      check(16'(n), 16'h0000);
    end
  endtask : rst_pulse

  // ==========================================================================
  // Main sequence
  logic [3:0] regs[5] = '{ADDR_ALARM_MONTH, ADDR_WATCHDOG, ADDR_CONTROL,
                          ADDR_SECONDS, ADDR_WEEKDAY};
  logic [7:0] msk[5]  = '{MASK_ALARM, 8'hff, 8'hff, 8'hff, MASK_WEEKDAY};
  logic [3:0] w_a[10] = '{ADDR_WEEKDAY, ADDR_CONTROL, ADDR_CONTROL,
                          ADDR_ALARM_MONTH, ADDR_ALARM_MONTH, ADDR_WATCHDOG,
                          ADDR_WATCHDOG, ADDR_SECONDS, ADDR_SECONDS,
                          ADDR_WEEKDAY};
  logic [7:0] w_d[10] = '{8'h40, 8'h3f, 8'h1f, 8'h80, 8'h00,
                          8'h05, 8'h85, 8'h80, 8'h00, 8'h00};
  logic       w_on[10] = '{1, 1, 1, 0, 1, 0, 1, 0, 1, 0};

  initial
  begin
    logic [7:0] d;
    power_up(1'b0, 1'b1);
    rd(ADDR_FLAGS, 8'h10);
    bat_ok <= 1'b1;
    repeat (20) @(posedge clk);
    rd(ADDR_FLAGS, 8'h10);
    for (int i = 0; i < 5; i++)
      rd(regs[i], REG_RST);
    for (int i = 0; i < 5; i++)
    begin
      d = 8'($random(seed));
      wr(regs[i], d);
      rd(regs[i], d & msk[i]);
    end
    wr(4'h3, 8'hff);
    rd(4'h3, 8'h00);
    wr(ADDR_FLAGS, 8'h00);
    rd(ADDR_FLAGS, 8'h10);
    power_up(1'b0, 1'b0);
    for (int i = 0; i < 5; i++)
      rd(regs[i], REG_RST);
    repeat (50) @(posedge clk);
    rd(ADDR_FLAGS, 8'h00);
    main_ok <= 1'b1;
    repeat (10) @(posedge clk);
    rd(ADDR_FLAGS, 8'h10);
    power_up(1'b1, 1'b1);
    rd(ADDR_FLAGS, 8'h00);
    for (int i = 0; i < 10; i++)
    begin
      wr(w_a[i], w_d[i]);
      wave(w_on[i]);
    end
    // Request lengths stand for 48 ns, 200 ns, 15 ms and 100 ms.
    rst_pulse(1'b0, 6, 1'b0, 1'b0);
    rst_pulse(1'b0, 25, 1'b1, 1'b0);
    rst_pulse(1'b1, 15, 1'b0, 1'b0);
    rst_pulse(1'b1, 5 * FB, 1'b1, 1'b1);
    end_sim();
  end

endmodule : rcb_core_bench
